/* File: ssp_params.svh */
// Purpose: offsets, field positions, reset values and counts of the serial port
// Assumes: 8-bit register port, 40 MHz system clock
// Notes: definitions only
// Function
// - master samples at end or middle per sample_phase
// - clock edge bit picks data change edge
// - buffer_full set on received byte
// - buffer read clears buffer_full
// - disable clears stop-detected bit
// - write while busy ignored, sets write_collision
// - slave overflow keeps old byte, sticky
// - master mode never sets overflow
// - port_enable claims or releases port pins
// - clock_idle_polarity sets serial clock idle level
// - codes 0101 and 0100 select slave modes
// - codes 0000-0010 master at clock /4,/16,/64
// - code 0011 master at period timer /2
// - eight bits, most significant bit first
// - byte to buffer, flags set, next begins
// - master buffer write starts transfer at once
// - master drives data output even when only receiving
// - slave shifts on external clock, flags byte
// - slave runs in sleep, byte wakes device
// - both share polarity, opposite shift edges
// - select high releases slave output mid-byte
// - module reset zeroes bit counter
// - buffer write loads shift register too
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_ADDR_BUF 8'h13
`define SSP_ADDR_CTRL 8'h14
`define SSP_ADDR_STAT 8'h94
`define SSP_CTRL_RESET 8'h00
`define SSP_STAT_RESET 8'h00
`define SSP_BIT_WRITE_COLLISION 7
`define SSP_BIT_OVF 6
`define SSP_BIT_EN 5
`define SSP_BIT_CKP 4
`define SSP_BIT_SMP 7
`define SSP_BIT_CKE 6
`define SSP_BIT_STOP 4
`define SSP_BIT_BF 0
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_MTMR 4'h3
`define SSP_MODE_SSEL 4'h4
`define SSP_MODE_SFREE 4'h5
`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20
`define SSP_EDGES 5'h10
`define SSP_EDGES_LATE 5'h11
`endif

/* File: ssp_peer.sv */
// Purpose: far-side serial party, slave or master
// Assumes: clock idles low, data changes on falling, sampled on rising
// Notes: send makes the clock itself
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_data,
    output logic o_sck,
    output logic o_data
);
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;
    initial o_sck = 1'b0;
    assign o_data = tx_q[7];
    always @(posedge i_sck) begin
        rx_q <= {rx_q[6:0], i_data};
    end
    always @(negedge i_sck) begin
        tx_q <= {tx_q[6:0], 1'b0};
    end
    task load(input logic [7:0] v);
        tx_q = v;
    endtask
    task send(input logic [7:0] v);
        tx_q = v;
        repeat (8) begin
            repeat (8) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (8) @(posedge i_clk);
            o_sck <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: ssp_pkg.sv */
// Purpose: shared types of the serial port
// Assumes: nothing beyond the params header
// Notes: types only
package ssp_pkg;
    typedef enum logic [0:0] {
        SSP_IDLE = 1'b0,
        SSP_XFER = 1'b1
    } ssp_state_e;
    typedef struct packed {
        logic write_collision;
        logic ovf;
        logic en;
        logic clock_idle_polarity;
        logic [3:0] mode;
    } ssp_ctrl_s;
    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic sdo;
        logic sdo_oe_n;
    } ssp_pins_s;
endpackage

/* File: ssp_port.sv */
// Purpose: SPI-mode synchronous serial port, master and slave
// Assumes: single clock, slave clock oversampled through synchronisers
// Notes: register port reads answer one cycle after the strobe
//
// The address-and-strobe port was decided locally.
`include "ssp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_sck_in,
    input wire logic i_sdi,
    input wire logic i_ss_n,
    input wire logic i_timer_tick,
    input wire logic i_sleep,
    output ssp_pkg::ssp_pins_s o_pins,
    output logic o_pins_claimed,
    output logic o_port_irq,
    output logic o_wake
);
    // reset release
    logic rst_meta_q;
    logic rst_q;
    wire rst_n = rst_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end

    // pin synchronisers
    logic sck_s;
    logic sdi_s;
    logic ss_n_s;

    ssp_sync3 #(
        .WIDTH(3),
        .RST_VAL(3'h1)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_async({i_sck_in, i_sdi, i_ss_n}),
        .o_sync({sck_s, sdi_s, ss_n_s})
    );

    // registers
    ssp_pkg::ssp_ctrl_s ctrl_q;
    ssp_pkg::ssp_state_e state_q;
    logic smp_q;
    logic cke_q;
    logic stop_q;
    logic bf_q;
    logic [7:0] buf_q;
    logic [7:0] sr_q;
    logic [2:0] rx_cnt_q;
    logic [2:0] tx_cnt_q;
    logic [5:0] div_q;
    logic [4:0] tick_q;
    logic sck_q;
    logic sdo_q;
    logic sck_prev_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic wake_q;
    logic [3:0] m_rx_pipe_q;

    // address decode
    wire hit_ctrl = (i_addr == `SSP_ADDR_CTRL);
    wire hit_stat = (i_addr == `SSP_ADDR_STAT);
    wire hit_buf = (i_addr == `SSP_ADDR_BUF);
    wire wr_ctrl = i_wr & hit_ctrl;
    wire wr_stat = i_wr & hit_stat;
    wire wr_buf = i_wr & hit_buf;
    wire rd_buf = i_rd & hit_buf;

    // mode decode
    wire en = ctrl_q.en;
    wire clock_idle_polarity = ctrl_q.clock_idle_polarity;
    wire [3:0] mode = ctrl_q.mode;
    wire is_master = en & (mode[3:2] == 2'b00);
    wire mode_ssel = (mode == `SSP_MODE_SSEL);
    wire mode_sfree = (mode == `SSP_MODE_SFREE);
    wire is_slave = en & (mode_ssel | mode_sfree);
    wire slave_rst = is_slave & mode_ssel & ss_n_s;
    wire slave_sel = is_slave & ~slave_rst;
    wire cnt_clr = ~en | slave_rst;

    // slave clock edges, taken from the partner's clock
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire s_lead = clock_idle_polarity ? sck_fall : sck_rise;
    wire s_trail = clock_idle_polarity ? sck_rise : sck_fall;
    // slave samples opposite the transmit edge, sample_phase assumed clear
    wire s_tx = slave_sel & (cke_q ? s_trail : s_lead);
    wire s_rx = slave_sel & (cke_q ? s_lead : s_trail);

    // master bit-rate generator
    wire [5:0] half_lim = (mode == `SSP_MODE_M4) ? `SSP_HALF_DIV4 :
                          (mode == `SSP_MODE_M16) ? `SSP_HALF_DIV16 :
                          `SSP_HALF_DIV64;
    wire busy_m = (state_q == ssp_pkg::SSP_XFER);
    wire run = busy_m & is_master & ~i_sleep;
    wire div_end = (div_q == (half_lim - 6'h01));
    wire div_hit = (mode == `SSP_MODE_MTMR) ? i_timer_tick : div_end;
    wire mtick = run & div_hit;
    wire edge_ok = (tick_q < `SSP_EDGES);
    wire lead = ~tick_q[0];
    wire mid_now = cke_q ? lead : ~lead;
    wire mid_prev = cke_q ? tick_q[0] : ~tick_q[0];
    wire m_rx_pt = smp_q ? ((tick_q != 5'h00) & mid_prev) : (edge_ok & mid_now);
    wire m_rx = mtick & m_rx_pt;
    wire m_tx = mtick & edge_ok & (cke_q ? ~lead : lead);
    wire [4:0] tick_nxt = tick_q + 5'h01;
    wire [4:0] tick_end = (~cke_q & smp_q) ? `SSP_EDGES_LATE : `SSP_EDGES;
    wire m_last = mtick & (tick_nxt == tick_end);

    // shared shift events
    wire busy_s = is_slave & ((rx_cnt_q != 3'h0) | (tx_cnt_q != 3'h0));
    wire busy = busy_m | busy_s | (|m_rx_pipe_q);
    wire tx_evt = m_tx | s_tx;
    wire rx_evt = (m_rx_pipe_q[3] & is_master) | s_rx;
    wire rx_done = rx_evt & (rx_cnt_q == 3'h7);
    wire [7:0] rx_byte = {sr_q[6:0], sdi_s};
    wire [2:0] tx_nxt = tx_cnt_q + 3'h1;
    wire tx_bit = cke_q ? buf_q[~tx_nxt] : buf_q[~tx_cnt_q];

    // buffer write acceptance
    wire wr_take = wr_buf & ~busy;
    wire write_collision_set = wr_buf & busy;
    wire start = wr_take & is_master;
    wire ovf_set = rx_done & is_slave & bf_q & ~rd_buf;
    wire rx_store = rx_done & ~ovf_set;

    // flag next values, hardware set wins
    wire write_collision_d = write_collision_set | (wr_ctrl ? i_wdata[`SSP_BIT_WRITE_COLLISION] : ctrl_q.write_collision);
    wire ovf_d = ovf_set | (wr_ctrl ? i_wdata[`SSP_BIT_OVF] : ctrl_q.ovf);
    wire bf_d = rx_store | (bf_q & ~rd_buf);

    // read mux
    wire [7:0] stat_val = {smp_q, cke_q, 1'b0, stop_q, 3'h0, bf_q};
    wire [7:0] ctrl_val = ctrl_q;
    wire [7:0] rd_val = hit_ctrl ? ctrl_val :
                        hit_stat ? stat_val :
                        hit_buf ? buf_q : 8'h00;

    // control register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SSP_CTRL_RESET;
        end else begin
            ctrl_q.write_collision <= write_collision_d;
            ctrl_q.ovf <= ovf_d;
            if (wr_ctrl) begin
                ctrl_q.en <= i_wdata[`SSP_BIT_EN];
                ctrl_q.clock_idle_polarity <= i_wdata[`SSP_BIT_CKP];
                ctrl_q.mode <= i_wdata[3:0];
            end
        end
    end

    // status register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= 1'(`SSP_STAT_RESET >> `SSP_BIT_SMP);
            cke_q <= 1'b0;
        end else if (wr_stat) begin
            smp_q <= i_wdata[`SSP_BIT_SMP];
            cke_q <= i_wdata[`SSP_BIT_CKE];
        end
    end

    // stop-detected bit, never set by this mode
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'b0;
        end else if (~en) begin
            stop_q <= 1'b0;
        end
    end

    // buffer-full flag
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            bf_q <= 1'b0;
        end else begin
            bf_q <= bf_d;
        end
    end

    // transfer buffer
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= 8'h00;
        end else if (wr_take) begin
            buf_q <= i_wdata;
        end else if (rx_store) begin
            buf_q <= rx_byte;
        end
    end

    // byte shift register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= 8'h00;
        end else if (wr_take) begin
            sr_q <= i_wdata;
        end else if (rx_evt) begin
            sr_q <= rx_byte;
        end
    end

    // receive bit counter
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_q <= 3'h0;
        end else if (cnt_clr | start) begin
            rx_cnt_q <= 3'h0;
        end else if (rx_evt) begin
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    // transmit bit counter
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_q <= 3'h0;
        end else if (cnt_clr | start) begin
            tx_cnt_q <= 3'h0;
        end else if (tx_evt) begin
            tx_cnt_q <= tx_nxt;
        end
    end

    // serial data output
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_q <= 1'b0;
        end else if (wr_take) begin
            sdo_q <= i_wdata[7];
        end else if (slave_rst) begin
            sdo_q <= buf_q[7];
        end else if (tx_evt) begin
            sdo_q <= tx_bit;
        end
    end

    // master sequencer
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ssp_pkg::SSP_IDLE;
        end else begin
            case (state_q)
                ssp_pkg::SSP_IDLE: begin
                    if (start) begin
                        state_q <= ssp_pkg::SSP_XFER;
                    end
                end
                ssp_pkg::SSP_XFER: begin
                    if (~is_master | m_last) begin
                        state_q <= ssp_pkg::SSP_IDLE;
                    end
                end
                default: begin
                    state_q <= ssp_pkg::SSP_IDLE;
                end
            endcase
        end
    end

    // master sample delayed by the data input synchroniser latency
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_rx_pipe_q <= 4'h0;
        end else begin
            m_rx_pipe_q <= {m_rx_pipe_q[2:0], m_rx};
        end
    end

    // half-period divider
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 6'h00;
        end else if (~run | div_hit) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    // clock edge counter
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 5'h00;
        end else if (start) begin
            tick_q <= 5'h00;
        end else if (mtick) begin
            tick_q <= tick_nxt;
        end
    end

    // master serial clock
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else if (~busy_m | ~is_master) begin
            sck_q <= clock_idle_polarity;
        end else if (mtick & edge_ok) begin
            sck_q <= ~sck_q;
        end
    end

    // slave clock history
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // byte events, slave ones run regardless of sleep
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= rx_done;
            wake_q <= rx_done & is_slave;
        end
    end

    // register read port
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_val : 8'h00;
        end
    end

    // pin drive
    assign o_pins.sck = sck_q;
    assign o_pins.sck_oe_n = ~is_master;
    assign o_pins.sdo = sdo_q;
    assign o_pins.sdo_oe_n = ~(is_master | slave_sel);
    assign o_pins_claimed = en;
    assign o_port_irq = irq_q;
    assign o_wake = wake_q;
    assign o_rdata = rdata_q;
endmodule
`default_nettype wire

/* File: ssp_port_chk.sv */
// Purpose: port checker of the serial port
// Assumes: bound to ssp_port
// Notes: follows control writes locally
`include "ssp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssp_port_chk (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_ss_n,
    input wire ssp_pkg::ssp_pins_s o_pins,
    input wire logic o_pins_claimed,
    input wire logic o_port_irq,
    input wire logic o_wake
);
    logic [7:0] ctl_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_q <= 8'h00;
        end else if (i_wr && i_addr == `SSP_ADDR_CTRL) begin
            ctl_q <= i_wdata;
        end
    end
    property p_claim;
        i_wr && i_addr == `SSP_ADDR_CTRL |=> o_pins_claimed == $past(i_wdata[5]);
    endproperty
    a_claim: assert property (p_claim) else $error("claim not from enable");
    property p_release;
        !o_pins_claimed && $past(!o_pins_claimed) |-> o_pins.sck_oe_n && o_pins.sdo_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("pins driven while off");
    property p_slave_nosck;
        ctl_q[2] && $past(ctl_q[2]) |-> o_pins.sck_oe_n;
    endproperty
    a_slave_nosck: assert property (p_slave_nosck) else $error("slave drives clock");
    property p_master_drv;
        ctl_q[5] && ctl_q[3:2] == 2'b00 && $past(ctl_q[5] && ctl_q[3:2] == 2'b00)
            |-> !o_pins.sck_oe_n && !o_pins.sdo_oe_n;
    endproperty
    a_master_drv: assert property (p_master_drv) else $error("master pins idle");
    property p_idle_irq;
        // a last trailing edge may follow the final sample by one half period
        o_port_irq && !o_pins.sck_oe_n |-> ##[0:32] o_pins.sck == ctl_q[4];
    endproperty
    a_idle_irq: assert property (p_idle_irq) else $error("clock not idle at end");
    property p_no_ovf;
        i_rd && i_addr == `SSP_ADDR_CTRL && ctl_q[3:2] == 2'b00 |=> !o_rdata[6];
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("overflow in master");
    property p_wake;
        o_port_irq && ctl_q[3:1] == 3'b010 |-> o_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("slave byte without wake");
    property p_irq_pulse;
        o_port_irq |=> !o_port_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("flag pulse too long");
    property p_ss_rel;
        (ctl_q[5] && ctl_q[3:0] == 4'h4 && i_ss_n) [*8] |-> o_pins.sdo_oe_n;
    endproperty
    a_ss_rel: assert property (p_ss_rel) else $error("output kept when deselected");
endmodule
bind ssp_port ssp_port_chk u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ss_n(i_ss_n), .o_pins(o_pins),
    .o_pins_claimed(o_pins_claimed), .o_port_irq(o_port_irq), .o_wake(o_wake)
);
`default_nettype wire

/* File: ssp_port_test.sv */
// Purpose: self-checking bench of the serial port
// Assumes: 40 MHz clock, peer model on the link
// Notes: read data sampled in the cycle after the strobe
`include "ssp_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); \
    end \
end
module ssp_port_test;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_ss_n = 1'b1;
    logic i_timer_tick = 1'b0;
    logic i_sleep = 1'b0;
    logic [7:0] o_rdata;
    ssp_pkg::ssp_pins_s o_pins;
    logic o_pins_claimed, o_port_irq, o_wake, peer_sck, peer_data, sck_w, sdo_w;
    logic tgl = 1'b0;
    logic wake_seen = 1'b0;
    logic [2:0] tick_div = 3'h0;
    logic [7:0] txs [4] = '{8'hA5, 8'h3C, 8'h81, 8'h5E};
    logic [7:0] rxs [4] = '{8'h96, 8'hC3, 8'h7E, 8'h18};
    logic [7:0] stats [4] = '{8'h40, 8'hC0, 8'h40, 8'h40};
    int halfs [4] = '{2, 8, 32, 5};
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    assign sck_w = o_pins.sck_oe_n ? peer_sck : o_pins.sck;
    assign sdo_w = o_pins.sdo_oe_n ? tgl : o_pins.sdo;
    ssp_port uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck_in(sck_w), .i_sdi(peer_data),
        .i_ss_n(i_ss_n), .i_timer_tick(i_timer_tick), .i_sleep(i_sleep), .o_pins(o_pins),
        .o_pins_claimed(o_pins_claimed), .o_port_irq(o_port_irq), .o_wake(o_wake)
    );
    ssp_peer u_peer (
        .i_clk(i_clk), .i_sck(sck_w), .i_data(sdo_w), .o_sck(peer_sck), .o_data(peer_data)
    );
    task test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        v = o_rdata;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        tgl <= ~tgl;
        tick_div <= (tick_div == 3'h4) ? 3'h0 : tick_div + 3'h1;
        i_timer_tick <= (tick_div == 3'h4);
        if (o_wake === 1'b1) wake_seen <= 1'b1;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        logic [7:0] v;
        int st;
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk(`SSP_ADDR_CTRL, `SSP_CTRL_RESET);
        rchk(`SSP_ADDR_STAT, `SSP_STAT_RESET);
        rchk(8'h55, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(`SSP_ADDR_STAT, stats[m]);
            wr(`SSP_ADDR_CTRL, 8'h20 | m[7:0]);
            u_peer.load(rxs[m]);
            wr(`SSP_ADDR_BUF, txs[m]);
            @(negedge i_clk);
            st = cyc;
            `CHK(o_pins.sdo, txs[m][7])
            wr(`SSP_ADDR_BUF, 8'hFF);
            rchk(`SSP_ADDR_CTRL, 8'hA0 | m[7:0]);
            while (o_port_irq !== 1'b1) @(negedge i_clk);
            `CHK(cyc - st >= 14 * halfs[m] && cyc - st <= 17 * halfs[m] + 2, 1'b1)
            `CHK(u_peer.rx_q, txs[m])
            repeat (36) @(negedge i_clk);
            rchk(`SSP_ADDR_STAT, stats[m] | 8'h01);
            rd(`SSP_ADDR_BUF, v);
            `CHK(v, rxs[m])
            rchk(`SSP_ADDR_STAT, stats[m]);
            wr(`SSP_ADDR_CTRL, 8'h20 | m[7:0]);
        end
        wr(`SSP_ADDR_CTRL, 8'h30);
        repeat (3) @(negedge i_clk);
        `CHK(o_pins.sck, 1'b1)
        wr(`SSP_ADDR_CTRL, 8'h00);
        @(negedge i_clk);
        `CHK(o_pins_claimed, 1'b0)
        rchk(`SSP_ADDR_STAT, 8'h40);
        wr(`SSP_ADDR_STAT, 8'h40);
        wr(`SSP_ADDR_CTRL, 8'h24);
        wr(`SSP_ADDR_BUF, 8'hC3);
        i_ss_n <= 1'b0;
        i_sleep <= 1'b1;
        repeat (8) @(posedge i_clk);
        u_peer.send(8'h5A);
        repeat (8) @(posedge i_clk);
        `CHK(u_peer.rx_q, 8'hC3)
        `CHK(wake_seen, 1'b1)
        i_ss_n <= 1'b1;
        repeat (8) @(negedge i_clk);
        `CHK(o_pins.sdo_oe_n, 1'b1)
        wr(`SSP_ADDR_CTRL, 8'h25);
        u_peer.send(8'h96);
        repeat (8) @(posedge i_clk);
        rchk(`SSP_ADDR_BUF, 8'h5A);
        wr(`SSP_ADDR_BUF, 8'h3C);
        rchk(`SSP_ADDR_CTRL, 8'h65);
        test_done();
    end
endmodule
`default_nettype wire

/* File: ssp_sync3.sv */
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ssp_sync3 #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_q <= RST_VAL[g];
                    s2_q <= RST_VAL[g];
                    s3_q <= RST_VAL[g];
                    out_q <= RST_VAL[g];
                end else begin
                    s1_q <= i_async[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign o_sync[g] = out_q;
        end
    endgenerate
endmodule
`default_nettype wire
